// >>> usrc_pkg.sv
package usrc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_RCSC = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_IRQ_ST = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // ==========================================================
    // receive_status_control fields
    localparam int BIT_NINTH = 0;
    localparam int BIT_OVERRUN_ERROR_FLAG = 1;
    localparam int BIT_FRAMING_ERROR_FLAG = 2;
    localparam int BIT_ADDRESS_DETECT_ENABLE = 3;
    localparam int BIT_CONTINUOUS_RX_ENABLE = 4;
    localparam int BIT_SINGLE_RX_ENABLE = 5;
    localparam int BIT_RX9 = 6;
    localparam logic [7:0] RCSC_WR_MASK = 8'h78;
    localparam logic [7:0] RCSC_RST = 8'h00;

    // ==========================================================
    // Mode register fields
    localparam int BIT_SYNC = 0;
    localparam int BIT_MASTER = 1;
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_RST = 2'h0;

    // ==========================================================
    // Interrupt status and mask fields
    localparam int IRQ_RX = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_FRM = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // ==========================================================
    // Bus constants
    localparam int HTRANS_BUSY_BIT = 1;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [31:0] HRDATA_RST = 32'h0000_0000;

    // Word delivered by the bit sampler
    typedef struct packed {
        logic valid;
        logic [8:0] data;
        logic frame_err;
    } usrc_rx_word_type;

    // Whole state of the control block
    typedef struct packed {
        logic [7:0] rcsc;
        logic [MODE_W-1:0] mode;
        logic [7:0] buf_data;
        logic buf_full;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic rx_en;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic rd_pend;
        logic [7:0] rd_addr;
        logic [31:0] hrdata;
        logic hreadyout;
    } usrc_state_type;

endpackage : usrc_pkg

// >>> usrc_rst_sync.sv
`timescale 1ns/1ps

// ==========================================================
// Reset release synchroniser
module usrc_rst_sync (
    // Clock and raw reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Released reset
    output logic nrst_sync_o
);

    logic meta_r;

    // Assert at once, release after two edges
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r <= 1'b0;
            nrst_sync_o <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            nrst_sync_o <= meta_r;
        end
    end

endmodule : usrc_rst_sync

// >>> usrc_top.sv
`timescale 1ns/1ps

// How it works
// R1: Sync master: writing single_rx_enable one starts one word, zero stops it.
// R2: Hardware clears single_rx_enable when its word has been received.
// R3: Sync slave: single_rx_enable has no effect on reception.
// R4: Async: continuous_rx_enable (bit 4) enables or disables reception.
// R5: Sync: continuous_rx_enable runs until cleared and overrides single_rx_enable.
// R6: Async 9-bit with address detect: only ninth-bit-one frames load and interrupt.
// R7: Address detect off: every frame accepted, ninth bit passed to software.
// R8: framing_error_flag (bit 2) updates when buffer read and next word loads.
// R9: overrun_error_flag (bit 1) sets on overrun, clears with continuous_rx_enable.
// R10: While overrun flag set, no new words are accepted.
module usrc_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Bit sampler side
    input wire usrc_pkg::usrc_rx_word_type rx_word_i,
    output logic rx_enable_o,
    // Interrupt
    output logic irq_o
);
    import usrc_pkg::*;

    logic rst_n;
    usrc_state_type s;
    usrc_state_type n;
    logic sync_mode;
    logic master_mode;
    logic single_mode;
    logic en_req;
    logic drop;
    logic take;
    logic ovr;
    logic hresp_r;

    // ==========================================================
    // Reset release
    usrc_rst_sync u_rst (
        .clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .nrst_sync_o(rst_n)
    );

    // ==========================================================
    // Receive enables and frame filtering
    assign sync_mode = s.mode[BIT_SYNC];
    assign master_mode = s.mode[BIT_MASTER];
    // Single receive only as sync master, and only without continuous
    assign single_mode = sync_mode && master_mode && s.rcsc[BIT_SINGLE_RX_ENABLE]
        && !s.rcsc[BIT_CONTINUOUS_RX_ENABLE]; // [R1] [R3] [R5]
    // Continuous wins in every mode; overrun holds reception off
    assign en_req = (s.rcsc[BIT_CONTINUOUS_RX_ENABLE] || single_mode)
        && !s.rcsc[BIT_OVERRUN_ERROR_FLAG]; // [R4] [R10]
    // Address frames only in async 9-bit with detect on
    assign drop = !sync_mode && s.rcsc[BIT_RX9] && s.rcsc[BIT_ADDRESS_DETECT_ENABLE]
        && !rx_word_i.data[8]; // [R6] [R7]
    // Current enables gate too, so the one-cycle lag of rx_en never lets a word in
    assign take = rx_word_i.valid && s.rx_en && en_req && !drop
        && !s.buf_full; // [R2] [R10]
    assign ovr = rx_word_i.valid && s.rx_en && en_req && !drop
        && s.buf_full; // [R10]

    // ==========================================================
    // Next state
    always_comb begin
        n = s;
        n.hreadyout = 1'b1;
        n.wr_pend = 1'b0;
        n.rd_pend = 1'b0;

        // Write data phase
        if (s.wr_pend) begin
            case (s.wr_addr)
                OFS_RCSC: begin
                    n.rcsc = (s.rcsc & ~RCSC_WR_MASK) | (hwdata_i[7:0] & RCSC_WR_MASK); // [R1]
                    if (!hwdata_i[BIT_CONTINUOUS_RX_ENABLE]) begin
                        n.rcsc[BIT_OVERRUN_ERROR_FLAG] = 1'b0; // [R9]
                    end
                end
                OFS_MODE: n.mode = hwdata_i[MODE_W-1:0];
                OFS_IRQ_ST: n.irq_st = s.irq_st & ~hwdata_i[IRQ_W-1:0];
                OFS_IRQ_MASK: n.irq_mask = hwdata_i[IRQ_W-1:0];
                default: n.mode = n.mode;
            endcase
        end

        // Read data phase, one wait state
        if (s.rd_pend) begin
            case (s.rd_addr)
                OFS_RCSC: n.hrdata = {24'h00_0000, s.rcsc};
                OFS_MODE: n.hrdata = {30'h0000_0000, s.mode};
                OFS_DATA: n.hrdata = {24'h00_0000, s.buf_data};
                OFS_IRQ_ST: n.hrdata = {29'h0000_0000, s.irq_st};
                OFS_IRQ_MASK: n.hrdata = {29'h0000_0000, s.irq_mask};
                default: n.hrdata = HRDATA_RST;
            endcase
            // Reading the buffer frees it for the next word
            if (s.rd_addr == OFS_DATA) begin
                n.buf_full = 1'b0; // [R8]
            end
        end

        // Address phase
        if (hsel_i && htrans_i[HTRANS_BUSY_BIT] && hready_i) begin
            if (hwrite_i) begin
                n.wr_pend = 1'b1;
                n.wr_addr = haddr_i[7:0];
            end else begin
                n.rd_pend = 1'b1;
                n.rd_addr = haddr_i[7:0];
                n.hreadyout = 1'b0;
            end
        end

        // Word completed by the sampler; set wins over clears above
        if (rx_word_i.valid && s.rx_en) begin
            if (single_mode) begin
                n.rcsc[BIT_SINGLE_RX_ENABLE] = 1'b0; // [R2]
            end
            if (take) begin
                n.buf_data = rx_word_i.data[7:0];
                n.buf_full = 1'b1;
                n.rcsc[BIT_NINTH] = rx_word_i.data[8] && s.rcsc[BIT_RX9]; // [R7]
                n.rcsc[BIT_FRAMING_ERROR_FLAG] = rx_word_i.frame_err; // [R8]
                n.irq_st[IRQ_RX] = 1'b1; // [R6]
                if (rx_word_i.frame_err) begin
                    n.irq_st[IRQ_FRM] = 1'b1;
                end
            end else if (ovr) begin
                n.rcsc[BIT_OVERRUN_ERROR_FLAG] = 1'b1; // [R9]
                n.irq_st[IRQ_OVR] = 1'b1;
            end
        end

        n.rx_en = en_req; // [R4] [R10]
        n.irq = |(n.irq_st & n.irq_mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s.rcsc <= RCSC_RST;
            s.mode <= MODE_RST;
            s.buf_data <= DATA_RST;
            s.buf_full <= 1'b0;
            s.irq_st <= IRQ_RST;
            s.irq_mask <= IRQ_RST;
            s.irq <= 1'b0;
            s.rx_en <= 1'b0;
            s.wr_pend <= 1'b0;
            s.wr_addr <= 8'h00;
            s.rd_pend <= 1'b0;
            s.rd_addr <= 8'h00;
            s.hrdata <= HRDATA_RST;
            s.hreadyout <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Response is always OKAY
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata_o = s.hrdata;
    assign hreadyout_o = s.hreadyout;
    assign hresp_o = hresp_r;
    assign rx_enable_o = s.rx_en;
    assign irq_o = s.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n);

    single_start_a: assert property ( // [R1]
        (sync_mode && master_mode && s.rcsc[BIT_SINGLE_RX_ENABLE] && !s.rcsc[BIT_CONTINUOUS_RX_ENABLE]
            && !s.rcsc[BIT_OVERRUN_ERROR_FLAG]) |=> s.rx_en)
        else $error("single receive did not enable reception");

    single_done_a: assert property ( // [R2]
        (single_mode && s.rx_en && rx_word_i.valid) |=> !s.rcsc[BIT_SINGLE_RX_ENABLE])
        else $error("single enable not cleared after word");

    slave_ignore_a: assert property ( // [R3]
        (sync_mode && !master_mode && !s.rcsc[BIT_CONTINUOUS_RX_ENABLE]) |=> !s.rx_en)
        else $error("sync slave receiving on single enable");

    async_continuous_rx_enable_a: assert property ( // [R4]
        !sync_mode && !s.rcsc[BIT_SINGLE_RX_ENABLE] |-> ##1 (s.rx_en == $past(
            s.rcsc[BIT_CONTINUOUS_RX_ENABLE] && !s.rcsc[BIT_OVERRUN_ERROR_FLAG])))
        else $error("async enable does not follow continuous bit");

    continuous_rx_enable_prio_a: assert property ( // [R5]
        (s.rcsc[BIT_CONTINUOUS_RX_ENABLE] && !s.wr_pend && s.rx_en && rx_word_i.valid)
            |=> (s.rcsc[BIT_SINGLE_RX_ENABLE] == $past(s.rcsc[BIT_SINGLE_RX_ENABLE])))
        else $error("single enable touched while continuous set");

    addr_filter_a: assert property ( // [R6]
        (rx_word_i.valid && s.rx_en && drop && !s.rd_pend)
            |=> (s.buf_full == $past(s.buf_full)) && !s.rcsc[BIT_OVERRUN_ERROR_FLAG]
                || $past(s.rcsc[BIT_OVERRUN_ERROR_FLAG]))
        else $error("data frame loaded under address detect");

    ninth_pass_a: assert property ( // [R7]
        take |=> (s.buf_full && s.rcsc[BIT_NINTH] == $past(
            rx_word_i.data[8] && s.rcsc[BIT_RX9])))
        else $error("ninth bit not passed through");

    framing_error_flag_load_a: assert property ( // [R8]
        take |=> (s.rcsc[BIT_FRAMING_ERROR_FLAG] == $past(rx_word_i.frame_err))
            && s.irq_st[IRQ_RX])
        else $error("framing flag not updated on load");

    ovr_set_a: assert property ( // [R9]
        (ovr && !s.rd_pend) |=> s.rcsc[BIT_OVERRUN_ERROR_FLAG] ##1 !s.rx_en)
        else $error("overrun not flagged");

    ovr_clear_a: assert property ( // [R9]
        (s.wr_pend && s.wr_addr == OFS_RCSC && !hwdata_i[BIT_CONTINUOUS_RX_ENABLE]
            && s.rcsc[BIT_OVERRUN_ERROR_FLAG]) |=> !s.rcsc[BIT_OVERRUN_ERROR_FLAG])
        else $error("overrun not cleared with continuous bit");

    ovr_block_a: assert property ( // [R10]
        s.rcsc[BIT_OVERRUN_ERROR_FLAG] |=> !s.rx_en)
        else $error("reception enabled during overrun");

endmodule : usrc_top

// >>> usrc_rx_peer.sv
`timescale 1ns/1ps

// ==========================================================
// Remote transmitter standing in for the bit sampler
module usrc_rx_peer (
    // Clock
    input wire logic clk_i,
    // Word toward the block
    output usrc_pkg::usrc_rx_word_type word_o
);
    import usrc_pkg::*;

    // Idle until the first word
    initial word_o = '0;

    // One word for one cycle, then the data lines scramble
    task send(input logic [8:0] d, input logic fe);
        @(posedge clk_i);
        word_o <= {1'b1, d, fe};
        @(posedge clk_i);
        word_o <= {1'b0, ~d, ~fe};
    endtask : send
endmodule : usrc_rx_peer

// >>> usart_receive_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %h got %h", n, e, g); fail_count++; end end

// ==========================================================
// Bench for the receive control block
module usart_receive_control_tb_top;
    import usrc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic rx_en;
    logic irq;
    logic [31:0] q;
    usrc_rx_word_type word;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;

    // Clock at 100 MHz
    always #5 clk = ~clk;

    usrc_top dut_u (.ref_clk_i(clk), .nrst_i(nrst), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .rx_word_i(word), .rx_enable_o(rx_en), .irq_o(irq));

    usrc_rx_peer peer_u (.clk_i(clk), .word_o(word));

    // ==========================================================
    // Bus and helper tasks
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb

    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(n, e, q)
        `CHK("hresp", 1'b0, hresp)
    endtask : rchk

    task st;
        repeat (3) @(posedge clk);
    endtask : st

    task tx(input logic [8:0] d, input logic fe);
        peer_u.send(d, fe);
        repeat (2) @(posedge clk);
    endtask : tx

    // ==========================================================
    // Scenarios
    task t_regs;
        rchk("rcsc_rst", OFS_RCSC, 32'h0);
        rchk("mask_rst", OFS_IRQ_MASK, 32'h0);
        wr(OFS_RCSC, 32'hFF);
        rchk("rcsc_rw", OFS_RCSC, {24'h0, RCSC_WR_MASK});
        wr(OFS_RCSC, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
    endtask : t_regs

    task t_async;
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_RCSC, 32'h10);
        st();
        `CHK("rx_en", 1'b1, rx_en)
        tx(9'h05A, 1'b1);
        `CHK("irq", 1'b1, irq)
        rchk("frm_st", OFS_IRQ_ST, 32'h5);
        rchk("data", OFS_DATA, 32'h5A);
        rchk("framing_error_flag", OFS_RCSC, 32'h14);
        wr(OFS_IRQ_ST, 32'h7);
        st();
        `CHK("irq_clr", 1'b0, irq)
        tx(9'h0C3, 1'b0);
        rchk("framing_error_flag_upd", OFS_RCSC, 32'h10);
        rchk("data2", OFS_DATA, 32'hC3);
        wr(OFS_RCSC, 32'h0);
        st();
        `CHK("rx_off", 1'b0, rx_en)
        wr(OFS_IRQ_ST, 32'h7);
        tx(9'h011, 1'b0);
        rchk("no_load", OFS_IRQ_ST, 32'h0);
    endtask : t_async

    task t_ovr;
        wr(OFS_RCSC, 32'h10);
        st();
        tx(9'h001, 1'b0);
        tx(9'h002, 1'b0);
        rchk("overrun_error_flag", OFS_RCSC, 32'h12);
        rchk("kept", OFS_DATA, 32'h01);
        rchk("ovr_st", OFS_IRQ_ST, 32'h3);
        wr(OFS_IRQ_ST, 32'h7);
        tx(9'h003, 1'b0);
        rchk("stall", OFS_IRQ_ST, 32'h0);
        wr(OFS_RCSC, 32'h0);
        rchk("overrun_error_flag_clr", OFS_RCSC, 32'h0);
    endtask : t_ovr

    task t_addr;
        wr(OFS_RCSC, 32'h58);
        st();
        wr(OFS_IRQ_ST, 32'h7);
        tx(9'h0AA, 1'b0);
        rchk("filt", OFS_IRQ_ST, 32'h0);
        tx(9'h1BB, 1'b0);
        rchk("addr_st", OFS_RCSC, 32'h59);
        rchk("addr_d", OFS_DATA, 32'hBB);
        wr(OFS_RCSC, 32'h50);
        st();
        tx(9'h033, 1'b0);
        rchk("all_d", OFS_DATA, 32'h33);
        rchk("all_st", OFS_RCSC, 32'h50);
        tx(9'h133, 1'b0);
        rchk("par_st", OFS_RCSC, 32'h51);
        rchk("par_d", OFS_DATA, 32'h33);
        wr(OFS_RCSC, 32'h0);
    endtask : t_addr

    task t_sync;
        wr(OFS_MODE, 32'h1);
        wr(OFS_RCSC, 32'h20);
        st();
        `CHK("slave", 1'b0, rx_en)
        wr(OFS_MODE, 32'h3);
        rchk("mode", OFS_MODE, 32'h3);
        st();
        `CHK("single_on", 1'b1, rx_en)
        wr(OFS_RCSC, 32'h0);
        st();
        `CHK("single_off", 1'b0, rx_en)
        wr(OFS_RCSC, 32'h20);
        st();
        tx(9'h044, 1'b0);
        st();
        `CHK("single_done", 1'b0, rx_en)
        rchk("single_rx_enable_clr", OFS_RCSC, 32'h0);
        rchk("single_d", OFS_DATA, 32'h44);
        wr(OFS_RCSC, 32'h30);
        st();
        tx(9'h055, 1'b0);
        st();
        `CHK("cont_run", 1'b1, rx_en)
        rchk("continuous_rx_enable_kept", OFS_RCSC, 32'h30);
    endtask : t_sync

    // ==========================================================
    // Verdict and run control
    task finish_test;
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_async();
        t_ovr();
        t_addr();
        t_sync();
        finish_test();
    end
endmodule : usart_receive_control_tb_top
